// ---- hw/fgml_defines.vh ----
// constants for the framer global mask and loopback block
`ifndef FGML_DEFINES_VH
`define FGML_DEFINES_VH
// register addresses
`define FGML_ADDR_MASK_TWO 12'h903
`define FGML_ADDR_LOOPBACK 12'h904
// reset values
`define FGML_RST_MASK_TWO 16'h0000
`define FGML_RST_LOOPBACK 16'h0000
// writable bits of each register
`define FGML_MASK_TWO_WMASK 16'h03ff
`define FGML_LOOPBACK_WMASK 16'hffc0
// loopback field positions
`define FGML_BIT_BP_ALL 15
`define FGML_BIT_BP_67 14
`define FGML_BIT_BP_45 13
`define FGML_BIT_BP_23 12
`define FGML_BIT_BP_01 11
`define FGML_BIT_LN_ALL 10
`define FGML_BIT_LN_67 9
`define FGML_BIT_LN_45 8
`define FGML_BIT_LN_23 7
`define FGML_BIT_LN_01 6
// mask field positions
`define FGML_BIT_F6_RXLINE 9
`define FGML_BIT_F6_SYNC 8
`define FGML_BIT_F5_HDLC 7
`define FGML_BIT_F5_ELASTIC 6
`define FGML_BIT_F5_RXLINE 5
`define FGML_BIT_F5_SYNC 4
`define FGML_BIT_F4_HDLC 3
`define FGML_BIT_F4_ELASTIC 2
`define FGML_BIT_F4_RXLINE 1
`define FGML_BIT_F4_SYNC 0
`endif

// ---- hw/fgml_pair_swap.v ----
// one loopback crossing of a pair of streams
`timescale 1ns/1ps
module fgml_pair_swap #(
    parameter W = 1
) (
    // control
    input wire i_en,
    // streams leaving each side
    input wire [W-1:0] i_out_a,
    input wire [W-1:0] i_out_b,
    // streams entering each side
    input wire [W-1:0] i_in_a,
    input wire [W-1:0] i_in_b,
    // resulting streams into each side
    output wire [W-1:0] o_in_a,
    output wire [W-1:0] o_in_b
);
    // when enabled each side hears the other's output
    assign o_in_a = i_en ? i_out_b : i_in_a;
    assign o_in_b = i_en ? i_out_a : i_in_b;
endmodule // fgml_pair_swap

// ---- hw/fgml_top.v ----
// vector mask two, global loopback and the loopback routing
`timescale 1ns/1ps
`include "fgml_defines.vh"
module fgml_top (
    // clock and reset
    input wire i_clk_sys,
    input wire i_resetn,
    // parallel host access
    input wire [11:0] i_addr,
    input wire i_cs_n,
    input wire i_wr_n,
    input wire i_rd_n,
    input wire [15:0] i_wdata,
    output reg [15:0] o_rdata,
    // per-category interrupt sources, framers 4 to 6
    input wire [7:0] i_fr4_hdlc_irq,
    input wire [7:0] i_fr4_elastic_irq,
    input wire [7:0] i_fr4_rxline_irq,
    input wire [7:0] i_fr4_sync_irq,
    input wire [7:0] i_fr5_hdlc_irq,
    input wire [7:0] i_fr5_elastic_irq,
    input wire [7:0] i_fr5_rxline_irq,
    input wire [7:0] i_fr5_sync_irq,
    input wire [7:0] i_fr6_rxline_irq,
    input wire [7:0] i_fr6_sync_irq,
    // vector status bits 9..0 of vector register two
    output reg [9:0] o_vec_status_two,
    // backplane streams, index = framer
    input wire [7:0] i_backplane_serial_out,
    input wire [7:0] i_backplane_serial_in,
    output wire [7:0] o_backplane_serial_in,
    // line rails, index = framer
    input wire [7:0] i_line_out_positive,
    input wire [7:0] i_line_out_negative,
    input wire [7:0] i_line_in_positive,
    input wire [7:0] i_line_in_negative,
    output wire [7:0] o_line_in_positive,
    output wire [7:0] o_line_in_negative
);
    // register contents
    reg [15:0] mask_two_q;
    reg [15:0] loopback_q;
    // host strobes
    wire wr_mask;
    wire wr_loop;
    // raw vector status before masking
    wire [9:0] vec_raw;
    // intermediate stream sets after each crossing stage
    wire [7:0] bp_s1;
    wire [7:0] bp_s2;
    wire [7:0] ln_s1_p;
    wire [7:0] ln_s1_n;
    wire [7:0] ln_s2_p;
    wire [7:0] ln_s2_n;
    // read strobe, any address
    wire rd_any;
    // next values of the registers
    reg [15:0] mask_two_d;
    reg [15:0] loopback_d;
    reg [15:0] rdata_d;
    reg [9:0] vec_status_d;

    // limitations a user must know:
    // - rate limits of the pair crossings are software's duty;
    //   nothing here looks at the backplane rate
    // - with an all-framer crossing and a pair crossing on at
    //   once, framers 0 and 4 hear the all-framer crossing,
    //   their pair partners still hear the pair crossing
    // - routing is pure logic, so a loopback bit acts on the
    //   streams as soon as the register holds it
    // - vector status is not sticky; it follows the sources

    // decoded write strobes, active while cs and wr are low
    assign wr_mask = ~i_cs_n & ~i_wr_n & (i_addr == `FGML_ADDR_MASK_TWO);
    assign wr_loop = ~i_cs_n & ~i_wr_n & (i_addr == `FGML_ADDR_LOOPBACK);
    // decoded read strobe, active while cs and rd are low
    assign rd_any = ~i_cs_n & ~i_rd_n;

    // next mask value; upper mask bits live elsewhere
    always @* begin
        mask_two_d = mask_two_q; // hold by default
        if (wr_mask) begin
            // keep only the field of framers 4 to 6
            mask_two_d = i_wdata & `FGML_MASK_TWO_WMASK;
        end
    end

    // next loopback value; bits 5..0 never store
    always @* begin
        loopback_d = loopback_q; // hold by default
        if (wr_loop) begin
            // unused bits dropped so they read zero
            loopback_d = i_wdata & `FGML_LOOPBACK_WMASK;
        end
    end

    // register state, cleared by reset
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            mask_two_q <= `FGML_RST_MASK_TWO;
            loopback_q <= `FGML_RST_LOOPBACK;
        end else begin
            mask_two_q <= mask_two_d;
            loopback_q <= loopback_d;
        end
    end

    // read data mux; holds the last answer when no read
    always @* begin
        rdata_d = o_rdata; // hold by default
        if (rd_any) begin
            case (i_addr)
                `FGML_ADDR_MASK_TWO: begin
                    rdata_d = mask_two_q; // low field only
                end
                `FGML_ADDR_LOOPBACK: begin
                    rdata_d = loopback_q;
                end
                default: begin
                    rdata_d = 16'h0000; // unmapped reads give zero
                end
            endcase
        end
    end

    // read data register
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= rdata_d;
        end
    end

    // each vector bit is the or of its category source
    // framer 6: receive line and sync only
    assign vec_raw[`FGML_BIT_F6_RXLINE] = |i_fr6_rxline_irq;
    assign vec_raw[`FGML_BIT_F6_SYNC] = |i_fr6_sync_irq;
    // framer 5: all four categories
    assign vec_raw[`FGML_BIT_F5_HDLC] = |i_fr5_hdlc_irq;
    assign vec_raw[`FGML_BIT_F5_ELASTIC] = |i_fr5_elastic_irq;
    assign vec_raw[`FGML_BIT_F5_RXLINE] = |i_fr5_rxline_irq;
    assign vec_raw[`FGML_BIT_F5_SYNC] = |i_fr5_sync_irq;
    // framer 4: all four categories
    assign vec_raw[`FGML_BIT_F4_HDLC] = |i_fr4_hdlc_irq;
    assign vec_raw[`FGML_BIT_F4_ELASTIC] = |i_fr4_elastic_irq;
    assign vec_raw[`FGML_BIT_F4_RXLINE] = |i_fr4_rxline_irq;
    assign vec_raw[`FGML_BIT_F4_SYNC] = |i_fr4_sync_irq;

    // masked status; a set mask bit forces zero
    always @* begin
        vec_status_d = vec_raw & ~mask_two_q[9:0];
    end

    // masked status registered, so a mask write acts next cycle
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_vec_status_two <= 10'h000;
        end else begin
            o_vec_status_two <= vec_status_d;
        end
    end

    // routing summary, what each framer index hears:
    //   0: pin, or out 1 by pair, or out 4 when all is on
    //   1: pin, or out 0 by pair
    //   2: pin, or out 3 by pair
    //   3: pin, or out 2 by pair
    //   4: pin, or out 5 by pair, or out 0 when all is on
    //   5: pin, or out 4 by pair
    //   6: pin, or out 7 by pair
    //   7: pin, or out 6 by pair
    // backplane streams and line rails share this map

    // backplane stage one: pair crossings, fed from the pins
    // framers 0 and 1
    fgml_pair_swap #(.W(1)) u_bp01 (
        .i_en(loopback_q[`FGML_BIT_BP_01]),
        .i_out_a(i_backplane_serial_out[0]),
        .i_out_b(i_backplane_serial_out[1]),
        .i_in_a(i_backplane_serial_in[0]),
        .i_in_b(i_backplane_serial_in[1]),
        .o_in_a(bp_s1[0]),
        .o_in_b(bp_s1[1])
    );

    // framers 2 and 3
    fgml_pair_swap #(.W(1)) u_bp23 (
        .i_en(loopback_q[`FGML_BIT_BP_23]),
        .i_out_a(i_backplane_serial_out[2]),
        .i_out_b(i_backplane_serial_out[3]),
        .i_in_a(i_backplane_serial_in[2]),
        .i_in_b(i_backplane_serial_in[3]),
        .o_in_a(bp_s1[2]),
        .o_in_b(bp_s1[3])
    );

    // framers 4 and 5
    fgml_pair_swap #(.W(1)) u_bp45 (
        .i_en(loopback_q[`FGML_BIT_BP_45]),
        .i_out_a(i_backplane_serial_out[4]),
        .i_out_b(i_backplane_serial_out[5]),
        .i_in_a(i_backplane_serial_in[4]),
        .i_in_b(i_backplane_serial_in[5]),
        .o_in_a(bp_s1[4]),
        .o_in_b(bp_s1[5])
    );

    // framers 6 and 7
    fgml_pair_swap #(.W(1)) u_bp67 (
        .i_en(loopback_q[`FGML_BIT_BP_67]),
        .i_out_a(i_backplane_serial_out[6]),
        .i_out_b(i_backplane_serial_out[7]),
        .i_in_a(i_backplane_serial_in[6]),
        .i_in_b(i_backplane_serial_in[7]),
        .o_in_a(bp_s1[6]),
        .o_in_b(bp_s1[7])
    );
    // backplane stage two: all-framer crossing 0 and 4 wins
    // framers 0 and 4, fed from stage one
    fgml_pair_swap #(.W(1)) u_bp_all (
        .i_en(loopback_q[`FGML_BIT_BP_ALL]),
        .i_out_a(i_backplane_serial_out[0]),
        .i_out_b(i_backplane_serial_out[4]),
        .i_in_a(bp_s1[0]),
        .i_in_b(bp_s1[4]),
        .o_in_a(bp_s2[0]),
        .o_in_b(bp_s2[4])
    );
    // other framers pass stage two untouched
    assign bp_s2[3:1] = bp_s1[3:1];
    assign bp_s2[7:5] = bp_s1[7:5];
    // streams handed to the framers
    assign o_backplane_serial_in = bp_s2;

    // line stage one: rail pair crossings, both rails together
    // framers 0 and 1
    fgml_pair_swap #(.W(2)) u_ln01 (
        .i_en(loopback_q[`FGML_BIT_LN_01]),
        .i_out_a({i_line_out_positive[0], i_line_out_negative[0]}),
        .i_out_b({i_line_out_positive[1], i_line_out_negative[1]}),
        .i_in_a({i_line_in_positive[0], i_line_in_negative[0]}),
        .i_in_b({i_line_in_positive[1], i_line_in_negative[1]}),
        .o_in_a({ln_s1_p[0], ln_s1_n[0]}),
        .o_in_b({ln_s1_p[1], ln_s1_n[1]})
    );

    // framers 2 and 3
    fgml_pair_swap #(.W(2)) u_ln23 (
        .i_en(loopback_q[`FGML_BIT_LN_23]),
        .i_out_a({i_line_out_positive[2], i_line_out_negative[2]}),
        .i_out_b({i_line_out_positive[3], i_line_out_negative[3]}),
        .i_in_a({i_line_in_positive[2], i_line_in_negative[2]}),
        .i_in_b({i_line_in_positive[3], i_line_in_negative[3]}),
        .o_in_a({ln_s1_p[2], ln_s1_n[2]}),
        .o_in_b({ln_s1_p[3], ln_s1_n[3]})
    );

    // framers 4 and 5
    fgml_pair_swap #(.W(2)) u_ln45 (
        .i_en(loopback_q[`FGML_BIT_LN_45]),
        .i_out_a({i_line_out_positive[4], i_line_out_negative[4]}),
        .i_out_b({i_line_out_positive[5], i_line_out_negative[5]}),
        .i_in_a({i_line_in_positive[4], i_line_in_negative[4]}),
        .i_in_b({i_line_in_positive[5], i_line_in_negative[5]}),
        .o_in_a({ln_s1_p[4], ln_s1_n[4]}),
        .o_in_b({ln_s1_p[5], ln_s1_n[5]})
    );

    // framers 6 and 7
    fgml_pair_swap #(.W(2)) u_ln67 (
        .i_en(loopback_q[`FGML_BIT_LN_67]),
        .i_out_a({i_line_out_positive[6], i_line_out_negative[6]}),
        .i_out_b({i_line_out_positive[7], i_line_out_negative[7]}),
        .i_in_a({i_line_in_positive[6], i_line_in_negative[6]}),
        .i_in_b({i_line_in_positive[7], i_line_in_negative[7]}),
        .o_in_a({ln_s1_p[6], ln_s1_n[6]}),
        .o_in_b({ln_s1_p[7], ln_s1_n[7]})
    );
    // line stage two: framer 0 and 4 crossing wins
    // framers 0 and 4, fed from stage one
    fgml_pair_swap #(.W(2)) u_ln_all (
        .i_en(loopback_q[`FGML_BIT_LN_ALL]),
        .i_out_a({i_line_out_positive[0], i_line_out_negative[0]}),
        .i_out_b({i_line_out_positive[4], i_line_out_negative[4]}),
        .i_in_a({ln_s1_p[0], ln_s1_n[0]}),
        .i_in_b({ln_s1_p[4], ln_s1_n[4]}),
        .o_in_a({ln_s2_p[0], ln_s2_n[0]}),
        .o_in_b({ln_s2_p[4], ln_s2_n[4]})
    );
    // other framers pass stage two untouched
    assign ln_s2_p[3:1] = ln_s1_p[3:1];
    assign ln_s2_p[7:5] = ln_s1_p[7:5];
    assign ln_s2_n[3:1] = ln_s1_n[3:1];
    assign ln_s2_n[7:5] = ln_s1_n[7:5];
    // rails handed to the framers
    assign o_line_in_positive = ln_s2_p;
    assign o_line_in_negative = ln_s2_n;
endmodule // fgml_top

// ---- verif/fgml_chk.sv ----
// port assertions for the mask and loopback block
`timescale 1ns/1ps
module fgml_chk (
    // clock, reset and host access
    input wire i_clk_sys, input wire i_resetn,
    input wire [11:0] i_addr, input wire i_cs_n,
    input wire i_wr_n, input wire i_rd_n,
    input wire [15:0] i_wdata, input wire [15:0] o_rdata,
    // interrupt sources and vector status
    input wire [7:0] i_fr4_hdlc_irq, i_fr4_elastic_irq,
    input wire [7:0] i_fr4_rxline_irq, i_fr4_sync_irq,
    input wire [7:0] i_fr5_hdlc_irq, i_fr5_elastic_irq,
    input wire [7:0] i_fr5_rxline_irq, i_fr5_sync_irq,
    input wire [7:0] i_fr6_rxline_irq, i_fr6_sync_irq,
    input wire [9:0] o_vec_status_two,
    // streams and rails
    input wire [7:0] i_backplane_serial_out, i_backplane_serial_in,
    input wire [7:0] o_backplane_serial_in,
    input wire [7:0] i_line_out_positive, i_line_out_negative,
    input wire [7:0] i_line_in_positive, i_line_in_negative,
    input wire [7:0] o_line_in_positive, o_line_in_negative
);
    reg [15:0] mk_q; // shadow of the mask register
    reg [15:0] lp_q; // shadow of the loopback register
    wire wr = !i_cs_n && !i_wr_n;
    wire rd = !i_cs_n && !i_rd_n;
    wire [9:0] ve = {|i_fr6_rxline_irq, |i_fr6_sync_irq, |i_fr5_hdlc_irq,
        |i_fr5_elastic_irq, |i_fr5_rxline_irq, |i_fr5_sync_irq,
        |i_fr4_hdlc_irq, |i_fr4_elastic_irq, |i_fr4_rxline_irq,
        |i_fr4_sync_irq} & ~mk_q[9:0];
    wire [7:0] bo = i_backplane_serial_out;
    wire [7:0] bi = o_backplane_serial_in;
    wire [7:0] tp = i_line_out_positive;
    wire [7:0] tn = i_line_out_negative;
    wire [7:0] rp = o_line_in_positive;
    wire [7:0] rn = o_line_in_negative;
    // shadow registers follow host writes
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            mk_q <= 16'h0000;
            lp_q <= 16'h0000;
        end else if (wr && i_addr == 12'h903) begin
            mk_q <= i_wdata & 16'h03ff;
        end else if (wr && i_addr == 12'h904) begin
            lp_q <= i_wdata & 16'hffc0;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    sequence s_rd(a); rd && i_addr == a; endsequence
    property p_rd_mk; s_rd(12'h903) |=> o_rdata == $past(mk_q); endproperty
    property p_rd_lp; s_rd(12'h904) |=> o_rdata == $past(lp_q); endproperty
    property p_vec(m); $past(i_resetn) |->
        ((o_vec_status_two ^ $past(ve)) & m) == 10'h000; endproperty
    property p_bp_all; lp_q[15] |-> bi[0] == bo[4] && bi[4] == bo[0];
    endproperty
    property p_bp_67; lp_q[14] |-> bi[6] == bo[7] && bi[7] == bo[6];
    endproperty
    property p_bp_low; (lp_q[13] |-> bi[5] == bo[4]) and
        (lp_q[12] |-> bi[3] == bo[2]) and (lp_q[11] |-> bi[1] == bo[0]);
    endproperty
    property p_ln_all; lp_q[10] |-> rp[0] == tp[4] && rn[4] == tn[0];
    endproperty
    property p_ln_pair; (lp_q[9] |-> rp[7] == tp[6] && rn[6] == tn[7]) and
        (lp_q[8] |-> rn[5] == tn[4]) and (lp_q[7] |-> rp[2] == tp[3]) and
        (lp_q[6] |-> rp[1] == tp[0]); endproperty
    property p_straight; lp_q == 16'h0000 |-> bi == i_backplane_serial_in
        && rp == i_line_in_positive && rn == i_line_in_negative; endproperty
    a_rd_mk: assert property (p_rd_mk)
        else $error("mask readback");
    a_rd_lp: assert property (p_rd_lp)
        else $error("loop readback");
    a_vec_f6: assert property (p_vec(10'h300))
        else $error("f6 vec");
    a_vec_f5: assert property (p_vec(10'h0f0))
        else $error("f5 vec");
    a_vec_f4: assert property (p_vec(10'h00f))
        else $error("f4 vec");
    a_bp_all: assert property (p_bp_all)
        else $error("bp all");
    a_bp_67: assert property (p_bp_67)
        else $error("bp 67");
    a_bp_low: assert property (p_bp_low)
        else $error("bp pair");
    a_ln_all: assert property (p_ln_all)
        else $error("line all");
    a_ln_pair: assert property (p_ln_pair)
        else $error("line pair");
    a_straight: assert property (p_straight)
        else $error("straight");
endmodule // fgml_chk

// ---- verif/tb.sv ----
// self-checking bench for the mask and loopback block
`timescale 1ns/1ps
module tb;
    reg clk = 1'b0, rstn = 1'b0, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
    reg [11:0] addr = 12'h000;
    reg [15:0] wd = 16'h0000;
    reg [79:0] src = 80'h0; // byte n drives vector bit n
    reg [7:0] bo = 8'h00, bi = 8'h00, lop = 8'h00, lon = 8'h00;
    reg [7:0] lip = 8'h00, lin = 8'h00;
    wire [15:0] rdata;
    wire [9:0] vec;
    wire [7:0] obi, olip, olin;
    integer n_fail = 0, tests_run = 0, cyc = 0, i, b, mk = 0, lp = 0;
    always #25 clk = ~clk;
    fgml_top dut_u (.i_clk_sys(clk), .i_resetn(rstn), .i_addr(addr),
        .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_wdata(wd),
        .o_rdata(rdata), .i_fr4_sync_irq(src[7:0]),
        .i_fr4_rxline_irq(src[15:8]), .i_fr4_elastic_irq(src[23:16]),
        .i_fr4_hdlc_irq(src[31:24]), .i_fr5_sync_irq(src[39:32]),
        .i_fr5_rxline_irq(src[47:40]), .i_fr5_elastic_irq(src[55:48]),
        .i_fr5_hdlc_irq(src[63:56]), .i_fr6_sync_irq(src[71:64]),
        .i_fr6_rxline_irq(src[79:72]), .o_vec_status_two(vec),
        .i_backplane_serial_out(bo), .i_backplane_serial_in(bi),
        .o_backplane_serial_in(obi), .i_line_out_positive(lop),
        .i_line_out_negative(lon), .i_line_in_positive(lip),
        .i_line_in_negative(lin), .o_line_in_positive(olip),
        .o_line_in_negative(olin));
    // verdict and end of run
    task close_out; begin
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end endtask
    task cmp(input [23:0] g, input [23:0] e); begin
        tests_run = tests_run + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    end endtask
    task chk_reg(input [15:0] e); cmp({8'h00, rdata}, {8'h00, e}); endtask
    task chk_vec(input [9:0] e); cmp({14'h0, vec}, {14'h0, e}); endtask
    task chk_rt(input [23:0] e); cmp({obi, olip, olin}, e); endtask
    // expected routing: pairs first, all-framer crossing wins
    function [23:0] rt(input [15:0] l);
        reg [7:0] e, p, n;
        integer k;
        begin
            e = bi; p = lip; n = lin;
            for (k = 0; k < 8; k = k + 2) begin
                if (l[11 + k/2]) begin e[k] = bo[k+1]; e[k+1] = bo[k]; end
                if (l[6 + k/2]) begin
                    p[k] = lop[k+1]; p[k+1] = lop[k];
                    n[k] = lon[k+1]; n[k+1] = lon[k];
                end
            end
            if (l[15]) begin e[0] = bo[4]; e[4] = bo[0]; end
            if (l[10]) begin
                p[0] = lop[4]; p[4] = lop[0]; n[0] = lon[4]; n[4] = lon[0];
            end
            rt = {e, p, n};
        end
    endfunction
    // one host cycle, held across one edge
    task acc(input w, input [11:0] a, input [15:0] d); begin
        cs_n = 1'b0; wr_n = !w; rd_n = w; addr = a; wd = d;
        @(posedge clk); #1;
        if (w && a == 12'h903) mk = d & 16'h03ff;
        if (w && a == 12'h904) lp = d & 16'hffc0;
    end endtask
    task idle; begin cs_n = 1'b1; wr_n = 1'b1; rd_n = 1'b1; end endtask
    task rd_chk(input [11:0] a); begin
        acc(1'b0, a, 16'h0000);
        chk_reg(a == 12'h903 ? mk : a == 12'h904 ? lp : 0);
    end endtask
    // new sources and streams, then check one edge later
    task step(input full); reg [9:0] e; begin
        for (b = 0; b < 10; b = b + 1)
            src[8*b +: 8] = full ? 8'hff : ($urandom % 2) ?
                8'h01 << ($urandom % 8) : 8'h00;
        {bo, bi, lop, lon} = $urandom;
        {lip, lin} = 16'($urandom);
        @(posedge clk); #1;
        for (b = 0; b < 10; b = b + 1) e[b] = |src[8*b +: 8] && !mk[b];
        chk_vec(e);
        chk_rt(rt(lp));
    end endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin n_fail = n_fail + 1; close_out; end
    end
    initial begin
        i = $urandom(83624);
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        rd_chk(12'h903); rd_chk(12'h904); rd_chk(12'h905); idle;
        step(1'b1);
        // each loopback bit alone, every unused bit too
        for (i = 0; i < 16; i = i + 1) begin
            acc(1'b1, 12'h904, 16'h0001 << i); rd_chk(12'h904); idle;
            step(1'b0); step(1'b0);
        end
        // each mask bit alone, acting on the very next cycle
        for (i = 0; i < 16; i = i + 1) begin
            acc(1'b1, 12'h903, 16'h0001 << i); idle;
            step(1'b1); rd_chk(12'h903); idle;
        end
        // random back-to-back traffic, unmapped address included
        for (i = 0; i < 60; i = i + 1) begin
            acc(1'b1, 12'h903 + 12'($urandom % 3), 16'($urandom));
            rd_chk(12'h903); rd_chk(12'h904); idle; step(1'b0);
        end
        acc(1'b1, 12'h904, 16'hffff); idle;
        // reset in mid-run returns everything to straight routing
        rstn = 1'b0; mk = 0; lp = 0; #1;
        chk_rt(rt(16'h0000)); chk_vec(10'h000);
        @(posedge clk); #1 rstn = 1'b1;
        rd_chk(12'h904); rd_chk(12'h903); idle; step(1'b1);
        close_out;
    end
endmodule // tb
bind fgml_top fgml_chk chk_u (.*);
